// ==== logic/phy_port_pkg.sv ====
// Package for the MAC-facing gigabit data port of the transceiver.
// Assumes a single 40 MHz system clock; the transmit link clock is a sampled input.
package phy_port_pkg;

	// ------------------------------------------------------------
	// Clocking and timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_PERIOD_NS = 25;
	// Half period of the generated receive clock, scaled for sampling
	localparam int RX_CLK_HALF_NS = 100;
	// Least time, rounded up to whole system cycles
	localparam int RX_HALF_CYCLES_INT =
		(RX_CLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int RX_PHASE_W = 4;
	localparam logic [RX_PHASE_W-1:0] RX_HALF_CYCLES =
		RX_PHASE_W'(RX_HALF_CYCLES_INT);
	localparam logic [RX_PHASE_W-1:0] RX_PHASE_LAST =
		RX_PHASE_W'(2 * RX_HALF_CYCLES_INT - 1);
	localparam logic [RX_PHASE_W-1:0] RX_PHASE_FALL =
		RX_PHASE_W'(RX_HALF_CYCLES_INT - 1);
	localparam logic [RX_PHASE_W-1:0] RX_PHASE_ZERO = 4'h0;
	localparam logic [RX_PHASE_W-1:0] RX_PHASE_ONE = 4'h1;
	// Cycles without a transmit clock rise before transmit counts idle;
	// above one 8-cycle link period, so a running frame never trips it
	localparam logic [RX_PHASE_W-1:0] TX_QUIET_LAST = 4'hA;

	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	localparam int STRAP_W = 3;
	localparam logic [STRAP_W-1:0] STRAP_BYTE_WIDE = 3'h0;
	localparam logic [STRAP_W-1:0] STRAP_DDR_A = 3'h4;
	localparam logic [STRAP_W-1:0] STRAP_DDR_B = 3'h6;
	// Cycles after reset release before the synchronised straps are used
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ------------------------------------------------------------
	// Data layout
	// ------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	// Sampled transmit bundle: clock, enable/control, error, data
	localparam int TX_BUS_W = 11;
	localparam int TX_BIT_CLK = 0;
	localparam int TX_BIT_EN = 1;
	localparam int TX_BIT_ER = 2;
	localparam int TX_BIT_D0 = 3;

	// Interface chosen at reset, one-hot
	typedef enum logic [2:0] {
		MODE_NONE = 3'b001,
		MODE_BYTE = 3'b010,
		MODE_DDR = 3'b100
	} port_mode_t;

endpackage : phy_port_pkg

// ==== logic/link_sampler.sv ====
// Two-flop synchroniser for a group of link pins, with edge pulses
// for bit 0, which carries a link clock.
// Assumes inputs are asynchronous to clk_i; bits of the group are
// only used at a detected clock edge, well after they settle.
`timescale 1ns/100ps
module link_sampler
#(
	parameter int W = 11
)
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] pins_i,
	output logic [W-1:0] sync_o,
	output logic rise_o,
	output logic fall_o
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	logic clk_prev_r;

	// ------------------------------------------------------------
	// Synchroniser: first stage read only by the second
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			meta_r <= '0;
			sync_r <= '0;
			clk_prev_r <= 1'b0;
		end
		else
		begin
			meta_r <= pins_i;
			sync_r <= meta_r;
			clk_prev_r <= sync_r[0];
		end
	end

	// Edge pulses come from settled stages only
	assign sync_o = sync_r;
	assign rise_o = sync_r[0] & ~clk_prev_r;
	assign fall_o = ~sync_r[0] & clk_prev_r;

endmodule : link_sampler

// ==== logic/phy_mac_port.sv ====
// MAC-facing data port of a gigabit copper transceiver, byte-wide
// and reduced double-data-rate forms at 1000 Mb/s.
// Assumes the media side hands bytes on the system clock and the MAC
// drives the transmit clock, sampled here as an ordinary input.
// Notes on behaviour
// - Straps 000 select byte-wide interface
// - Device makes receive clock, sends bytes
// - Receive error raised for bad frame
// - Receive valid held while delivering data
// - Carrier sense while receive medium busy
// - Half duplex: carrier on transmit, if enabled
// - Half duplex collision when both busy
// - Straps 100 or 110 select reduced interface
// - Reduced mode receive uses both clock edges
// - Reduced receive: low nibble rise, high fall
// - Receive control: valid rise, valid xor error fall
`timescale 1ns/100ps
module phy_mac_port
	import phy_port_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Strap pins
	input wire logic [STRAP_W-1:0] MAC_INTERFACE_SELECT_STRAPS_I,
	// MAC transmit pins
	input wire logic GTX_CLK_I,
	input wire logic TX_EN_I,
	input wire logic TX_ER_I,
	input wire logic [BYTE_W-1:0] TXD_I,
	// MAC receive pins
	output logic RX_CLK_O,
	output logic RX_DV_O,
	output logic RX_ER_O,
	output logic [BYTE_W-1:0] RXD_O,
	output logic CRS_O,
	output logic COL_O,
	// Configuration levels
	input wire logic HALF_DUPLEX_I,
	input wire logic CRS_ON_TX_I,
	// Media side, receive
	input wire logic RX_MEDIA_ACTIVE_I,
	input wire logic RX_MEDIA_VALID_I,
	input wire logic RX_MEDIA_ERR_I,
	input wire logic [BYTE_W-1:0] RX_MEDIA_DATA_I,
	output logic RX_TAKE_O,
	// Media side, transmit
	output logic TX_STROBE_O,
	output logic TX_ERR_O,
	output logic [BYTE_W-1:0] TX_DATA_O,
	output logic TX_BUSY_O,
	output logic [2:0] MODE_O
);

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	function automatic port_mode_t decode_mode(
		input logic [STRAP_W-1:0] straps
	);
		port_mode_t m;
		m = MODE_NONE;
		if (straps == STRAP_BYTE_WIDE)
			m = MODE_BYTE;
		else if (straps == STRAP_DDR_A || straps == STRAP_DDR_B)
			m = MODE_DDR;
		return m;
	endfunction : decode_mode

	function automatic logic mode_active(input port_mode_t m);
		return (m == MODE_BYTE) || (m == MODE_DDR);
	endfunction : mode_active

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [STRAP_W-1:0] strap_meta_r;
	logic [STRAP_W-1:0] strap_sync_r;
	logic [1:0] strap_wait_r;
	logic mode_locked_r;
	port_mode_t mode_r;

	logic [TX_BUS_W-1:0] tx_pins;
	logic [TX_BUS_W-1:0] tx_sync;
	logic tx_rise;
	logic tx_fall;
	logic tx_ctl;
	logic tx_er;
	logic [BYTE_W-1:0] txd;
	logic [NIB_W-1:0] tx_low_r;
	logic tx_en_rise_r;
	logic tx_busy_r;
	logic [RX_PHASE_W-1:0] tx_quiet_r;

	logic [RX_PHASE_W-1:0] rx_phase_r;
	logic [RX_PHASE_W-1:0] rx_phase_nxt;
	logic rx_at_rise;
	logic rx_at_fall;
	logic [BYTE_W-1:0] rx_byte_r;
	logic rx_valid_r;
	logic rx_err_r;
	logic port_on;

	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	// Straps are pins: synchronise, wait, then latch once
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			strap_meta_r <= '0;
			strap_sync_r <= '0;
		end
		else
		begin
			strap_meta_r <= MAC_INTERFACE_SELECT_STRAPS_I;
			strap_sync_r <= strap_meta_r;
		end
	end

	// Mode holds until the next reset, whatever the pins do later
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			strap_wait_r <= '0;
			mode_locked_r <= 1'b0;
			mode_r <= MODE_NONE;
		end
		else if (!mode_locked_r)
		begin
			if (strap_wait_r == STRAP_SETTLE)
			begin
				mode_locked_r <= 1'b1;
				mode_r <= decode_mode(strap_sync_r);
			end
			else
			begin
				strap_wait_r <= strap_wait_r + 2'h1;
			end
		end
	end

	assign port_on = mode_active(mode_r);

	// ------------------------------------------------------------
	// Transmit sampling
	// ------------------------------------------------------------
	// Clock and data pass the same two stages, so they stay aligned
	assign tx_pins = {TXD_I, TX_ER_I, TX_EN_I, GTX_CLK_I};

	link_sampler #(
		.W(TX_BUS_W)
	) u_tx_sampler (
		.clk_i(CLK_I),
		.resetn_i(RESETN_I),
		.pins_i(tx_pins),
		.sync_o(tx_sync),
		.rise_o(tx_rise),
		.fall_o(tx_fall)
	);

	assign tx_ctl = tx_sync[TX_BIT_EN];
	assign tx_er = tx_sync[TX_BIT_ER];
	assign txd = tx_sync[TX_BIT_D0 +: BYTE_W];

	// A clock held low by the MAC simply yields no edges
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			tx_low_r <= '0;
			tx_en_rise_r <= 1'b0;
		end
		else if (mode_r == MODE_DDR && tx_rise)
		begin
			tx_low_r <= txd[NIB_W-1:0];
			tx_en_rise_r <= tx_ctl;
		end
	end

	// Bytes to the media side; strobe only while enabled
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			TX_STROBE_O <= 1'b0;
			TX_ERR_O <= 1'b0;
			TX_DATA_O <= '0;
		end
		else
		begin
			TX_STROBE_O <= 1'b0;
			case (mode_r)
				MODE_BYTE:
				begin
					if (tx_rise && tx_ctl)
					begin
						TX_STROBE_O <= 1'b1;
						TX_DATA_O <= txd;
						TX_ERR_O <= tx_er;
					end
				end
				MODE_DDR:
				begin
					if (tx_fall && tx_en_rise_r)
					begin
						TX_STROBE_O <= 1'b1;
						TX_DATA_O <= {txd[NIB_W-1:0], tx_low_r};
						TX_ERR_O <= tx_en_rise_r ^ tx_ctl;
					end
				end
				default:
				begin
					TX_STROBE_O <= 1'b0;
				end
			endcase
		end
	end

	// Cycles since the last transmit clock rise, saturating
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			tx_quiet_r <= '0;
		else if (tx_rise)
			tx_quiet_r <= '0;
		else if (tx_quiet_r != TX_QUIET_LAST)
			tx_quiet_r <= tx_quiet_r + RX_PHASE_ONE;
	end

	// Transmit medium busy follows the enable seen at rising edges.
	// The MAC stops its clock after a frame, so a quiet clock ends busy,
	// else carrier and collision would stick on.
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			tx_busy_r <= 1'b0;
		else if (!port_on)
			tx_busy_r <= 1'b0;
		else if (tx_rise)
			tx_busy_r <= tx_ctl;
		else if (tx_quiet_r == TX_QUIET_LAST)
			tx_busy_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Receive clock divider
	// ------------------------------------------------------------
	// Phase LAST -> clock rises next; phase FALL -> clock falls next
	always_comb
	begin
		if (rx_phase_r == RX_PHASE_LAST)
			rx_phase_nxt = RX_PHASE_ZERO;
		else
			rx_phase_nxt = rx_phase_r + RX_PHASE_ONE;
	end

	assign rx_at_rise = port_on && (rx_phase_r == RX_PHASE_LAST);
	assign rx_at_fall = port_on && (rx_phase_r == RX_PHASE_FALL);

	// Stops, low, when no interface was chosen
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			rx_phase_r <= RX_PHASE_ZERO;
			RX_CLK_O <= 1'b0;
		end
		else if (!port_on)
		begin
			rx_phase_r <= RX_PHASE_ZERO;
			RX_CLK_O <= 1'b0;
		end
		else
		begin
			rx_phase_r <= rx_phase_nxt;
			if (rx_at_rise)
				RX_CLK_O <= 1'b1;
			else if (rx_at_fall)
				RX_CLK_O <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Receive data path
	// ------------------------------------------------------------
	// One media byte per receive clock period, taken at the rise
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			rx_byte_r <= '0;
			rx_valid_r <= 1'b0;
			rx_err_r <= 1'b0;
			RX_TAKE_O <= 1'b0;
		end
		else
		begin
			RX_TAKE_O <= rx_at_rise;
			if (rx_at_rise)
			begin
				rx_valid_r <= RX_MEDIA_VALID_I;
				rx_err_r <= RX_MEDIA_ERR_I;
				rx_byte_r <= RX_MEDIA_VALID_I ? RX_MEDIA_DATA_I : '0;
			end
		end
	end

	// Pins change together with the clock edge they belong to
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			RXD_O <= '0;
			RX_DV_O <= 1'b0;
			RX_ER_O <= 1'b0;
		end
		else
		begin
			case (mode_r)
				MODE_BYTE:
				begin
					if (rx_at_rise)
					begin
						RXD_O <= RX_MEDIA_VALID_I ? RX_MEDIA_DATA_I : '0;
						RX_DV_O <= RX_MEDIA_VALID_I;
						RX_ER_O <= RX_MEDIA_ERR_I;
					end
				end
				MODE_DDR:
				begin
					// Upper lines and separate error pin unused here
					RX_ER_O <= 1'b0;
					if (rx_at_rise)
					begin
						RXD_O <= {{NIB_W{1'b0}}, RX_MEDIA_DATA_I[NIB_W-1:0] &
							{NIB_W{RX_MEDIA_VALID_I}}};
						RX_DV_O <= RX_MEDIA_VALID_I;
					end
					else if (rx_at_fall)
					begin
						RXD_O <= {{NIB_W{1'b0}}, rx_byte_r[BYTE_W-1:NIB_W]};
						RX_DV_O <= rx_valid_r ^ rx_err_r;
					end
				end
				default:
				begin
					RXD_O <= '0;
					RX_DV_O <= 1'b0;
					RX_ER_O <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Carrier and collision
	// ------------------------------------------------------------
	// Level signals; carrier on transmit needs its enable bit
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			CRS_O <= 1'b0;
			COL_O <= 1'b0;
		end
		else if (!port_on)
		begin
			CRS_O <= 1'b0;
			COL_O <= 1'b0;
		end
		else
		begin
			CRS_O <= RX_MEDIA_ACTIVE_I |
				(HALF_DUPLEX_I & CRS_ON_TX_I & tx_busy_r);
			COL_O <= HALF_DUPLEX_I & RX_MEDIA_ACTIVE_I & tx_busy_r;
		end
	end

	// ------------------------------------------------------------
	// Status
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			TX_BUSY_O <= 1'b0;
			MODE_O <= MODE_NONE;
		end
		else
		begin
			TX_BUSY_O <= tx_busy_r;
			MODE_O <= mode_r;
		end
	end

endmodule : phy_mac_port

// ==== dv/mac_port_properties.sv ====
// Checker for the MAC-facing port, watching top-level ports only.
// Assumes one system clock domain and an active-low reset.
`timescale 1ns/100ps
module mac_port_chk
	import phy_port_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic TX_EN_I,
	input wire logic HALF_DUPLEX_I,
	input wire logic CRS_ON_TX_I,
	input wire logic TX_BUSY_O,
	input wire logic RX_MEDIA_ACTIVE_I,
	input wire logic RX_CLK_O,
	input wire logic RX_DV_O,
	input wire logic RX_ER_O,
	input wire logic [BYTE_W-1:0] RXD_O,
	input wire logic CRS_O,
	input wire logic COL_O,
	input wire logic RX_TAKE_O,
	input wire logic TX_STROBE_O,
	input wire logic [2:0] MODE_O
);
	// ------------------------------------------------------------
	// Port properties
	// ------------------------------------------------------------
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);

	a_mode_fixed: assert property (MODE_O != MODE_NONE |=> $stable(MODE_O))
		else $error("mode changed after capture");
	a_none_quiet: assert property (MODE_O == MODE_NONE |->
		!RX_CLK_O && !TX_STROBE_O) else $error("activity with no mode");
	a_rxclk_high: assert property ($rose(RX_CLK_O) |->
		RX_CLK_O [*4] ##1 !RX_CLK_O) else $error("receive clock shape");
	a_take_at_rise: assert property (RX_TAKE_O == $rose(RX_CLK_O))
		else $error("take not at clock rise");
	a_byte_hold: assert property (MODE_O == MODE_BYTE && !RX_TAKE_O |->
		$stable(RXD_O) && $stable(RX_DV_O) && $stable(RX_ER_O))
		else $error("byte receive pins moved mid period");
	a_ddr_unused: assert property (MODE_O == MODE_DDR |->
		!RX_ER_O && RXD_O[7:4] == 4'h0) else $error("reduced pins not idle");
	a_strobe_gap: assert property (TX_STROBE_O |=> !TX_STROBE_O [*4])
		else $error("transmit strobes too close");
	a_strobe_en: assert property (MODE_O == MODE_BYTE && TX_STROBE_O |->
		$past(TX_EN_I, 2)) else $error("byte taken without enable");
	a_crs_rx: assert property ($past(MODE_O) != MODE_NONE &&
		$past(RX_MEDIA_ACTIVE_I) |-> CRS_O) else $error("carrier missing");
	a_col_both: assert property ($past(MODE_O) != MODE_NONE &&
		!($past(HALF_DUPLEX_I) && $past(RX_MEDIA_ACTIVE_I)) |-> !COL_O)
		else $error("collision without cause");
	a_crs_tx: assert property ($past(MODE_O) != MODE_NONE &&
		$past(HALF_DUPLEX_I) && $past(CRS_ON_TX_I) && TX_BUSY_O |-> CRS_O)
		else $error("carrier on transmit missing");
	a_col_set: assert property ($past(MODE_O) != MODE_NONE &&
		$past(HALF_DUPLEX_I) && $past(RX_MEDIA_ACTIVE_I) && TX_BUSY_O
		|-> COL_O) else $error("collision missing");

	// Main scenarios reached
	c_ddr_fall: cover property (MODE_O == MODE_DDR && $fell(RX_CLK_O));
	c_byte_tx: cover property (MODE_O == MODE_BYTE && TX_STROBE_O);
	c_col: cover property (COL_O);
endmodule : mac_port_chk

bind phy_mac_port mac_port_chk u_chk (.*);

// ==== dv/mac_tx_model.sv ====
// MAC transmit side model: drives the transmit clock, control and data.
// Assumes the bench calls send and idle in sequence, one at a time.
`timescale 1ns/100ps
module mac_tx_model
(
	output logic gtx_clk_o,
	output logic tx_en_o,
	output logic tx_er_o,
	output logic [7:0] txd_o
);
	// ------------------------------------------------------------
	// Transfers
	// ------------------------------------------------------------
	// Clock low outside frames
	initial
	begin
		gtx_clk_o = 1'b0;
		tx_en_o = 1'b0;
		tx_er_o = 1'b0;
		txd_o = 8'h00;
	end

	// One 200 ns clock period per byte; reduced form swaps nibbles
	task automatic send(input logic ddr, input logic [7:0] d,
		input logic en, input logic er);
		txd_o = d;
		tx_en_o = en;
		tx_er_o = er;
		#75 gtx_clk_o = 1'b1;
		#50;
		// Fall values set mid high phase, held past the fall
		if (ddr)
		begin
			txd_o = {d[3:0], d[7:4]};
			tx_en_o = en ^ er;
		end
		#50 gtx_clk_o = 1'b0;
		#25;
	endtask : send

	// No pull on these lines, so show a changed value once released
	task automatic idle();
		tx_en_o = 1'b0;
		tx_er_o = 1'b0;
		txd_o = ~txd_o;
	endtask : idle
endmodule : mac_tx_model

// ==== dv/tb_top.sv ====
// Self-checking bench for the MAC-facing port.
// Assumes the MAC model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module tb_top;
	import phy_port_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, half = 1'b0, crs_tx = 1'b0;
	logic act = 1'b0, mv = 1'b0, me = 1'b0, ddr = 1'b0, prev = 1'b0;
	logic [2:0] straps = 3'h0;
	logic [7:0] md = 8'h00;
	logic [31:0] lfsr = 32'h5385;
	logic [14:0] rx_e;
	logic [8:0] txq[$];
	logic [14:0] rxq[$];
	int fail_count = 0, n_compared = 0, cyc = 0;
	wire gtx, ten, ter, rx_clk, rx_dv, rx_er, crs, col, take, stb, terr, busy;
	wire [7:0] txd, rxd, tdat;
	wire [2:0] mode;

	mac_tx_model u_mac (.gtx_clk_o(gtx), .tx_en_o(ten), .tx_er_o(ter),
		.txd_o(txd));
	phy_mac_port u_dut (.CLK_I(clk), .RESETN_I(rstn),
		.MAC_INTERFACE_SELECT_STRAPS_I(straps), .GTX_CLK_I(gtx),
		.TX_EN_I(ten), .TX_ER_I(ter), .TXD_I(txd), .RX_CLK_O(rx_clk),
		.RX_DV_O(rx_dv), .RX_ER_O(rx_er), .RXD_O(rxd), .CRS_O(crs),
		.COL_O(col), .HALF_DUPLEX_I(half), .CRS_ON_TX_I(crs_tx),
		.RX_MEDIA_ACTIVE_I(act), .RX_MEDIA_VALID_I(mv), .RX_MEDIA_ERR_I(me),
		.RX_MEDIA_DATA_I(md), .RX_TAKE_O(take), .TX_STROBE_O(stb),
		.TX_ERR_O(terr), .TX_DATA_O(tdat), .TX_BUSY_O(busy), .MODE_O(mode));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	always #12.5 clk = ~clk;

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// New media byte and config levels; idle bytes show as zero
	task automatic present();
		logic [31:0] r;
		logic [7:0] d;
		r = rnd();
		mv = r[0];
		me = r[0] & r[1] & r[2];
		md = r[15:8];
		{act, half, crs_tx} = r[5:3];
		d = mv ? md : 8'h00;
		rxq.push_back(ddr ? {mv ^ me, d[7:4], 1'b0, mv, 4'h0, d[3:0]}
			: {5'h00, me, mv, d});
	endtask : present

	// Reset with given straps, then expect the captured mode
	task automatic start(input logic [2:0] s, input logic [2:0] m);
		@(negedge clk);
		check("tx left", 16'(txq.size()), 16'h0000);
		rstn = 1'b0;
		straps = s;
		ddr = s[2];
		rxq.delete();
		txq.delete();
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		present();
		repeat (6) @(negedge clk);
		check("mode", {13'h0000, mode}, {13'h0000, m});
		straps = ~s;
	endtask : start

	// Byte 2 goes out with enable low and must be dropped
	task automatic frame(input int n, input logic acc);
		logic [31:0] r;
		#3;
		for (int k = 0; k < n; k++)
		begin
			r = rnd();
			if (acc && k != 2)
				txq.push_back({r[9] & r[8], r[7:0]});
			u_mac.send(ddr, r[7:0], k != 2, r[9] & r[8]);
			if (k == 0)
				check("tx busy", {15'h0000, busy}, {15'h0000, acc});
		end
		u_mac.idle();
		repeat (12) @(negedge clk);
		check("tx quiet", {15'h0000, busy}, 16'h0000);
	endtask : frame

	// ------------------------------------------------------------
	// Drivers and monitor
	// ------------------------------------------------------------
	// Media byte replaced right after the port took it
	always @(negedge clk)
	begin
		if (take === 1'b1 && rstn === 1'b1)
			present();
	end

	// Oldest note is compared whenever a result shows
	always @(posedge clk)
	begin
		#1;
		if (take === 1'b1)
		begin
			rx_e = rxq.pop_front();
			check("rx rise", {rx_er, rx_dv, rxd}, rx_e[9:0]);
		end
		if (rstn && ddr && prev && rx_clk === 1'b0)
			check("rx fall", {rx_dv, rxd}, {rx_e[14], 4'h0, rx_e[13:10]});
		prev = rx_clk;
		if (stb === 1'b1)
			check("tx byte", {terr, tdat}, txq.pop_front());
	end

	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			stop_test();
		end
	end

	initial
	begin
		start(3'h0, 3'h2);
		frame(7, 1'b1);
		repeat (40) @(negedge clk);
		check("mode held", {13'h0000, mode}, 16'h0002);
		start(3'h4, 3'h4);
		frame(7, 1'b1);
		start(3'h6, 3'h4);
		frame(4, 1'b1);
		start(3'h3, 3'h1);
		frame(3, 1'b0);
		check("idle pins", {rx_clk, crs, col}, 16'h0000);
		start(3'h0, 3'h2);
		stop_test();
	end
endmodule : tb_top
